// >>> hw/smt_consts.vh
// constants for the two-wire serial memory target
`ifndef SMT_CONSTS_VH
`define SMT_CONSTS_VH

// =====================================================
// address word layout
// type code value is arbitrary, chosen for this block only
`define SMT_TYPE_CODE      4'h5
`define SMT_TYPE_MSB       7
`define SMT_TYPE_LSB       4
`define SMT_SEL_MSB        3
`define SMT_SEL_LSB        1
`define SMT_DIR_BIT        0
`define SMT_DIR_WRITE      1'b0
`define SMT_DIR_READ       1'b1

// =====================================================
// array geometry
`define SMT_ADDR_W         16
`define SMT_DATA_W         8
`define SMT_ADDR_RST       16'h0000

// =====================================================
// bit counting
`define SMT_ACK_BIT        4'h8
`define SMT_BIT_RST        4'h0

`endif

// >>> hw/smt_buf2.v
// two-entry valid/ready buffer
`timescale 1ns/1ps

module smt_buf2 #(
    parameter WIDTH = 24
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_b_i,
    // fill side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg [WIDTH-1:0] mem_q [0:1];
    reg             wr_ptr_q;
    reg             rd_ptr_q;
    reg [1:0]       cnt_q;

    wire push = in_valid_i && (cnt_q != 2'd2);
    wire pop  = out_ready_i && (cnt_q != 2'd0);

    assign in_ready_o  = (cnt_q != 2'd2);
    assign out_valid_o = (cnt_q != 2'd0);
    assign out_data_o  = mem_q[rd_ptr_q];

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q    <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

endmodule // smt_buf2

// >>> hw/smt_target.v
// two-wire serial memory target with 64k x 8 array
`timescale 1ns/1ps
`include "smt_consts.vh"

// Contract
// - 65,536 bytes, 16-bit memory address
// - sample rising edge, drive falling edge
// - data output open-drain, low only
// - respond only when select code matches straps
// - unconnected strap reads low
// - write-protect high blocks array writes
// - reads work regardless of write-protect
// - unconnected write-protect means writable
// - data changes only while clock low
// - start: data falls while clock high
// - stop: data rises, end, standby
// - no write wait after stop
// - receiver acks low on ninth clock
// - transmitter releases line on ninth clock
// - stop before ack abandons operation
// - release bus after not-acknowledge
// - address word: type, select, direction
// - direction 0 write, 1 read
// - mismatch returns to standby without ack
module smt_target (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_b_i,
    // serial bus pins
    input  wire       scl_i,
    input  wire       sda_i,
    output reg        sda_o,
    output reg        sda_oe_o,
    // straps
    input  wire [2:0] strapped_select_pins_i,
    input  wire       wp_i,
    // status
    output reg        busy_o
);

    // =====================================================
    // pin synchronisers
    reg [1:0] scl_s_q;
    reg [1:0] sda_s_q;
    reg       scl_d1_q;
    reg       sda_d1_q;
    reg [2:0] sel_s1_q;
    reg [2:0] sel_q;
    reg       wp_s1_q;
    reg       wp_q;

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            scl_s_q  <= 2'b11;
            sda_s_q  <= 2'b11;
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
            sel_s1_q <= 3'b000;
            sel_q    <= 3'b000;
            wp_s1_q  <= 1'b0;
            wp_q     <= 1'b0;
        end else begin
            scl_s_q  <= {scl_s_q[0], scl_i};
            sda_s_q  <= {sda_s_q[0], sda_i};
            scl_d1_q <= scl_s_q[1];
            sda_d1_q <= sda_s_q[1];
            // floating straps are pulled low by the pad, so x never arrives here
            sel_s1_q <= strapped_select_pins_i;
            sel_q    <= sel_s1_q;
            wp_s1_q  <= wp_i;
            wp_q     <= wp_s1_q;
        end
    end

    wire scl_c   = scl_s_q[1];
    wire sda_c   = sda_s_q[1];
    wire scl_ris = scl_c & ~scl_d1_q;
    wire scl_fal = ~scl_c & scl_d1_q;
    // data moving while clock stays high marks a frame boundary
    wire start_e = scl_c & scl_d1_q & sda_d1_q & ~sda_c;
    wire stop_e  = scl_c & scl_d1_q & ~sda_d1_q & sda_c;

    // =====================================================
    // frame bookkeeping
    // the clock fall that closes a start is not a data bit; without
    // swallowing it every byte boundary would land one bit early
    reg  skip_q;

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            skip_q <= 1'b0;
        end else if (start_e) begin
            skip_q <= 1'b1;
        end else if (scl_fal && skip_q) begin
            skip_q <= 1'b0;
        end
    end

    wire bit_fal = scl_fal & ~skip_q;

    // =====================================================
    // protocol state
    localparam ST_IDLE  = 3'd0;
    localparam ST_DEV   = 3'd1;
    localparam ST_ADRH  = 3'd2;
    localparam ST_ADRL  = 3'd3;
    localparam ST_WDAT  = 3'd4;
    localparam ST_RDAT  = 3'd5;
    localparam ST_WAIT  = 3'd6;

    reg [2:0]                st_q;
    reg [3:0]                bit_q;
    reg [7:0]                sh_q;
    reg [7:0]                tx_q;
    reg                      ack_q;   // driving ack during ninth clock
    reg                      mack_q;  // controller ack sampled in read
    reg [`SMT_ADDR_W-1:0]    addr_q;

    // array: one write port, one read port
    reg [`SMT_DATA_W-1:0]    mem_q [0:(1<<`SMT_ADDR_W)-1];
    reg [`SMT_DATA_W-1:0]    rd_q;

    // =====================================================
    // write buffer
    // write path buffered so a held word is not lost
    wire                     wb_in_ready;
    wire                     wb_out_valid;
    wire [23:0]              wb_out_data;
    reg                      wb_push;
    reg  [23:0]              wb_data;

    smt_buf2 #(
        .WIDTH (24)
    ) u_wbuf (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (wb_push),
        .in_ready_o  (wb_in_ready),
        .in_data_i   (wb_data),
        .out_valid_o (wb_out_valid),
        .out_ready_i (1'b1),
        .out_data_o  (wb_out_data)
    );

    // =====================================================
    // array write port
    // array commits the moment the buffer drains: no wait after stop
    always @(posedge clk_i) begin
        if (wb_out_valid) begin
            mem_q[wb_out_data[23:8]] <= wb_out_data[7:0];
        end
    end

    // =====================================================
    // array read port
    // registered read keeps the next byte ready before the ninth fall
    always @(posedge clk_i) begin
        rd_q <= mem_q[addr_q];
    end

    // =====================================================
    // address word decode
    // judged on the fall after the eighth rise, when sh_q holds the whole word
    wire [7:0] sh_next  = {sh_q[6:0], sda_c};
    wire       type_ok  = (sh_q[`SMT_TYPE_MSB:`SMT_TYPE_LSB] == `SMT_TYPE_CODE);
    wire       sel_ok   = (sh_q[`SMT_SEL_MSB:`SMT_SEL_LSB] == sel_q);
    wire       dev_ok   = type_ok && sel_ok;
    wire       dir_rd   = (sh_q[`SMT_DIR_BIT] == `SMT_DIR_READ);
    wire       in_frame = (st_q != ST_IDLE) && (st_q != ST_WAIT);
    // a full buffer drops the byte rather than stretching the clock
    wire       wr_allow = !wp_q && wb_in_ready;

    // =====================================================
    // bit engine
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_q     <= ST_IDLE;
            bit_q    <= `SMT_BIT_RST;
            sh_q     <= 8'h00;
            tx_q     <= 8'h00;
            ack_q    <= 1'b0;
            mack_q   <= 1'b0;
            addr_q   <= `SMT_ADDR_RST;
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
            busy_o   <= 1'b0;
            wb_push  <= 1'b0;
            wb_data  <= 24'h00_0000;
        end else begin
            wb_push <= 1'b0;
            sda_o   <= 1'b0;
            if (stop_e) begin
                st_q     <= ST_IDLE;
                sda_oe_o <= 1'b0;
                ack_q    <= 1'b0;
                busy_o   <= 1'b0;
            end else if (start_e) begin
                st_q     <= ST_DEV;
                bit_q    <= `SMT_BIT_RST;
                sda_oe_o <= 1'b0;
                ack_q    <= 1'b0;
                busy_o   <= 1'b1;
            end else if (scl_ris) begin
                // sample only on the rising edge
                if (in_frame) begin
                    if (bit_q == `SMT_ACK_BIT) begin
                        mack_q <= ~sda_c;
                    end else begin
                        sh_q <= sh_next;
                    end
                end
            end else if (bit_fal) begin
                // all line changes happen while clock is low
                case (st_q)
                    ST_DEV, ST_ADRH, ST_ADRL, ST_WDAT: begin
                        if (bit_q == 4'd7) begin
                            bit_q <= `SMT_ACK_BIT;
                            if (st_q == ST_DEV && !dev_ok) begin
                                st_q   <= ST_WAIT;
                                busy_o <= 1'b0;
                            end else begin
                                ack_q    <= 1'b1;
                                sda_oe_o <= 1'b1;
                            end
                        end else if (bit_q == `SMT_ACK_BIT) begin
                            ack_q    <= 1'b0;
                            sda_oe_o <= 1'b0;
                            bit_q    <= `SMT_BIT_RST;
                            case (st_q)
                                ST_DEV: begin
                                    if (dir_rd) begin
                                        st_q     <= ST_RDAT;
                                        tx_q     <= rd_q;
                                        sda_oe_o <= ~rd_q[7];
                                    end else begin
                                        st_q <= ST_ADRH;
                                    end
                                end
                                ST_ADRH: begin
                                    addr_q[15:8] <= sh_q;
                                    st_q         <= ST_ADRL;
                                end
                                ST_ADRL: begin
                                    addr_q[7:0] <= sh_q;
                                    st_q        <= ST_WDAT;
                                end
                                default: begin
                                    // protected writes still ack but never reach the array
                                    if (wr_allow) begin
                                        wb_push <= 1'b1;
                                        wb_data <= {addr_q, sh_q};
                                    end
                                    addr_q <= addr_q + 16'h0001;
                                end
                            endcase
                        end else begin
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                    ST_RDAT: begin
                        if (bit_q == 4'd7) begin
                            bit_q    <= `SMT_ACK_BIT;
                            sda_oe_o <= 1'b0;
                            addr_q   <= addr_q + 16'h0001;
                        end else if (bit_q == `SMT_ACK_BIT) begin
                            bit_q <= `SMT_BIT_RST;
                            if (mack_q) begin
                                tx_q     <= rd_q;
                                sda_oe_o <= ~rd_q[7];
                            end else begin
                                st_q   <= ST_WAIT;
                                busy_o <= 1'b0;
                            end
                        end else begin
                            bit_q    <= bit_q + 4'h1;
                            tx_q     <= {tx_q[6:0], 1'b0};
                            sda_oe_o <= ~tx_q[6];
                        end
                    end
                    default: begin
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // smt_target

// >>> tb/smt_assertions.sv
// assertion checker for the serial memory target
`timescale 1ns/1ps
module smt_assertions (
    // clock and reset
    input wire       clk_i,
    input wire       rst_b_i,
    // pins and straps
    input wire       scl_i,
    input wire       sda_i,
    input wire       sda_o,
    input wire       sda_oe_o,
    input wire [2:0] strapped_select_pins_i,
    input wire       wp_i,
    input wire       busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // ==================================================
    // bus events seen on the raw pins
    sequence stop_s;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence
    sequence start_s;
        scl_i && $past(scl_i) && $fell(sda_i);
    endsequence
    AST_OPEN_DRAIN: assert property (sda_oe_o |-> sda_o == 1'b0) else $error("data driven high");
    AST_DRIVE_ON_LOW: assert property ($rose(sda_oe_o) |-> !$past(scl_i, 2)) else $error("drive began clock high");
    AST_RELEASE_ON_LOW: assert property ($fell(sda_oe_o) |-> !$past(scl_i, 2)) else $error("release clock high");
    AST_HOLD_BIT: assert property ($rose(sda_oe_o) |=> sda_oe_o [*4]) else $error("bit not held");
    AST_STOP_IDLE: assert property (stop_s |-> ##[1:6] (!busy_o && !sda_oe_o)) else $error("no standby");
    AST_START_QUIET: assert property (start_s |=> (!sda_oe_o) [*4]) else $error("drive at start");
    AST_FREE_AFTER_END: assert property ($fell(busy_o) |=> (!sda_oe_o) [*4]) else $error("bus kept");
    AST_RESET_QUIET: assert property ($rose(rst_b_i) |-> !busy_o && !sda_oe_o) else $error("busy after reset");
endmodule // smt_assertions

bind smt_target smt_assertions smt_assertions_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .strapped_select_pins_i(strapped_select_pins_i), .wp_i(wp_i),
    .busy_o(busy_o));

// >>> tb/smt_master.sv
// behavioural two-wire bus controller
`timescale 1ns/1ps
module smt_master (
    // bus pins
    output reg  scl_o,
    output reg  sda_oe_o,
    input  wire sda_i
);
    reg [8:0] res;
    event     got;
    integer   i;
    reg       r;
    reg [7:0] d;

    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // ==================================================
    // bit, byte and framing tasks
    task bitx(input b);
        begin
            #50 sda_oe_o = !b;
            #150 scl_o = 1'b1;
            #100 r = sda_i;
            #100 scl_o = 1'b0;
        end
    endtask
    task put(input [7:0] v);
        begin
            for (i = 7; i >= 0; i = i - 1)
                bitx(v[i]);
            bitx(1'b1);
            res = {1'b1, 7'h00, !r};
            -> got;
        end
    endtask
    task get(input nak);
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bitx(1'b1);
                d[i] = r;
            end
            bitx(nak);
            res = {1'b0, d};
            -> got;
        end
    endtask
    // late rise so a target still acking has let go
    task start;
        begin
            #50 sda_oe_o = 1'b0;
            #200 scl_o = 1'b1;
            #100 sda_oe_o = 1'b1;
            #100 scl_o = 1'b0;
        end
    endtask
    task stop;
        begin
            #50 sda_oe_o = 1'b1;
            #150 scl_o = 1'b1;
            #100 sda_oe_o = 1'b0;
            #300;
        end
    endtask
endmodule // smt_master

// >>> tb/smt_target_bench.sv
// self-checking bench for the serial memory target
`timescale 1ns/1ps
`include "smt_consts.vh"
module smt_target_bench;
    reg         clk_i   = 1'b0;
    reg         rst_b_i = 1'b0;
    reg         wp_i    = 1'b0;
    reg  [2:0]  sel_q   = 3'h0;
    wire        scl, m_oe, sda_o, sda_oe_o, busy_o;
    wire        sda     = !(m_oe || sda_oe_o);
    reg  [8:0]  exp_q[$];
    reg  [31:0] rnd     = 32'h0000_ad5c;
    reg  [7:0]  d0, d1, d2, w;
    integer     n_fail  = 0;
    integer     n_compared = 0;
    integer     i;

    smt_target smt_target_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .strapped_select_pins_i(sel_q), .wp_i(wp_i), .busy_o(busy_o));
    smt_master smt_master_i (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));

    initial forever #25 clk_i = !clk_i;
    // ==================================================
    // helpers
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task compare(input [8*4-1:0] nm, input [8:0] e, input [8:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task put(input [7:0] v, input a);
        begin
            exp_q.push_back({1'b1, 7'h00, a});
            smt_master_i.put(v);
        end
    endtask
    task get(input [7:0] v, input nak);
        begin
            exp_q.push_back({1'b0, v});
            smt_master_i.get(nak);
        end
    endtask
    task adr(input [15:0] a);
        begin
            smt_master_i.start;
            put({`SMT_TYPE_CODE, sel_q, 1'b0}, 1'b1);
            put(a[15:8], 1'b1);
            put(a[7:0], 1'b1);
        end
    endtask
    task rd;
        begin
            smt_master_i.start;
            put({`SMT_TYPE_CODE, sel_q, 1'b1}, 1'b1);
        end
    endtask
    task end_of_test;
        begin
            $display("compared %0d failed %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // oldest note against each result
    always @(smt_master_i.got)
        compare("resp", exp_q.size() ? exp_q.pop_front() : 9'h1ff, smt_master_i.res);
    initial begin
        #2_000_000;
        n_fail = n_fail + 1;
        $display("CHECK FAILED run exp done got timeout");
        end_of_test;
    end
    // ==================================================
    // scenarios
    initial begin
        repeat (5) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        repeat (6) @(posedge clk_i);
        #1 rnd = xs(rnd);
        sel_q = rnd[26:24];
        {d2, d1, d0} = rnd[23:0];
        adr(16'hffff);
        compare("busy", 9'h001, {8'h00, busy_o});
        put(d0, 1'b1);
        put(d1, 1'b1);
        put(d2, 1'b1);
        smt_master_i.stop;
        compare("busy", 9'h000, {8'h00, busy_o});
        adr(16'hffff);
        rd;
        get(d0, 1'b0);
        get(d1, 1'b0);
        get(d2, 1'b1);
        smt_master_i.stop;
        $display("burst with wrap done");
        wp_i = 1'b1;
        adr(16'h0000);
        put(~d1, 1'b1);
        smt_master_i.stop;
        adr(16'h0000);
        rd;
        get(d1, 1'b1);
        smt_master_i.stop;
        wp_i = 1'b0;
        $display("write protect done");
        for (i = 0; i < 9; i = i + 1) begin
            rnd = xs(rnd);
            sel_q = i[2:0];
            w = {(i == 8) ? `SMT_TYPE_CODE ^ 4'h1 : `SMT_TYPE_CODE, i[0] ? rnd[2:0] : i[2:0], 1'b0};
            smt_master_i.start;
            put(w, w == {`SMT_TYPE_CODE, sel_q, 1'b0});
            smt_master_i.stop;
            compare("busy", 9'h000, {8'h00, busy_o});
        end
        $display("select codes done");
        compare("left", 9'h000, 9'(exp_q.size()));
        end_of_test;
    end
endmodule // smt_target_bench
